// file: hw/acp_pkg.sv
// Shared constants and types for the converter control-pin logic.
// Assumes one 10 MHz clock and a synchronous active-high reset everywhere.
package acp_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int ACP_RES_BITS = 18;
  localparam int ACP_IDX_BITS = 5;
  localparam int ACP_CFG_BITS = 4;
  localparam int ACP_PIN_COUNT = 13;

  // ****************************************
  // Reset values and fixed codes
  // ****************************************
  localparam logic [ACP_CFG_BITS-1:0] ACP_CFG_RESET = 4'h0;
  localparam logic [ACP_RES_BITS-1:0] ACP_DATA_RESET = 18'h0_0000;
  localparam logic [ACP_RES_BITS-1:0] ACP_MSB_MASK = 18'h2_0000;
  localparam logic [ACP_IDX_BITS-1:0] ACP_MSB_IDX = 5'h11;
  // Active-low pins start released so no false edge is seen after reset
  localparam logic [ACP_PIN_COUNT-1:0] ACP_PIN_INIT = 13'h000E;

  // ****************************************
  // Configuration register fields
  // ****************************************
  localparam int ACP_CFG_BIPOLAR = 0;
  localparam int ACP_CFG_DOUBLE = 1;
  localparam int ACP_CFG_POWERDOWN = 2;
  localparam int ACP_CFG_CODING = 3;

  // ****************************************
  // Pin positions in the synchroniser vector
  // ****************************************
  localparam int ACP_PIN_RESET = 0;
  localparam int ACP_PIN_CONVERT_N = 1;
  localparam int ACP_PIN_READ_N = 2;
  localparam int ACP_PIN_SELECT_N = 3;
  localparam int ACP_PIN_POWERDOWN = 4;
  localparam int ACP_PIN_REF_SHDN = 5;
  localparam int ACP_PIN_BUF_SHDN = 6;
  localparam int ACP_PIN_BIPOLAR = 7;
  localparam int ACP_PIN_DOUBLE = 8;
  localparam int ACP_PIN_CODING = 9;
  localparam int ACP_PIN_SERIAL = 10;
  localparam int ACP_PIN_SCLK = 11;
  localparam int ACP_PIN_COMPARE = 12;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    RANGE_0_5, RANGE_0_10, RANGE_PM5, RANGE_PM10
  } acp_range_t;

  typedef enum logic [1:0] {
    SAR_IDLE, SAR_CONVERT, SAR_LATCH
  } acp_sar_state_t;

endpackage

// file: hw/acp_conv_if.sv
// Handshake between the pin logic and the approximation engine.
// Both ends run on the same clock; no crossing happens here.
interface acp_conv_if;
  import acp_pkg::*;
  logic start;
  logic abort;
  logic compare;
  logic busy;
  logic done;
  logic hold;
  logic [ACP_RES_BITS-1:0] result;
  logic [ACP_RES_BITS-1:0] trial;

  modport ctrl (output start, output abort, output compare,
                input busy, input done, input hold, input result, input trial);
  modport engine (input start, input abort, input compare,
                  output busy, output done, output hold, output result, output trial);
endinterface

// file: hw/acp_sync.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes pins are asynchronous to clk; the level moves once stages two and three agree.
module acp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk, // System clock
  input wire logic reset, // Synchronous reset
  input wire logic [W-1:0] pinIn, // Raw pins
  output logic [W-1:0] level // Filtered levels
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } acp_sync_state_t;

  acp_sync_state_t q;
  acp_sync_state_t d;

  always_comb begin
    d = q;
    d.s1 = pinIn;
    d.s2 = q.s1;
    d.s3 = q.s2;
    // Disagreement means the pin is still moving, so keep the old level
    d.lvl = (~(q.s2 ^ q.s3) & q.s2) | ((q.s2 ^ q.s3) & q.lvl);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      q <= '{s1: INIT, s2: INIT, s3: INIT, lvl: INIT};
    end else begin
      q <= d;
    end
  end

  assign level = q.lvl;
endmodule

// file: hw/acp_sar.sv
// Successive approximation engine: one result bit per clock, MSB first.
// Assumes the comparator answer for the current trial is valid each cycle.
module acp_sar
  import acp_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic reset, // Synchronous reset
  acp_conv_if.engine conv // Start, abort and result handshake
);
  typedef struct packed {
    acp_sar_state_t st;
    logic [ACP_IDX_BITS-1:0] idx;
    logic [ACP_RES_BITS-1:0] trial;
    logic [ACP_RES_BITS-1:0] result;
    logic busy;
    logic done;
    logic hold;
  } acp_sar_reg_t;

  acp_sar_reg_t q;
  acp_sar_reg_t d;

  always_comb begin
    d = q;
    d.done = 1'b0;
    case (q.st)
      SAR_IDLE: begin
        if (conv.start) begin
          d.st = SAR_CONVERT;
          d.busy = 1'b1;
          d.hold = 1'b1;
          d.idx = ACP_MSB_IDX;
          d.trial = ACP_MSB_MASK;
        end
      end
      SAR_CONVERT: begin
        if (!conv.compare) begin
          d.trial[q.idx] = 1'b0;
        end
        if (q.idx == '0) begin
          d.st = SAR_LATCH;
          d.result = d.trial;
          d.done = 1'b1;
        end else begin
          d.idx = q.idx - 1'b1;
          d.trial[q.idx - 1'b1] = 1'b1;
        end
      end
      SAR_LATCH: begin
        // Busy drops on the same edge that the shift register takes the result
        d.st = SAR_IDLE;
        d.busy = 1'b0;
        d.hold = 1'b0;
      end
      default: begin
        d.st = SAR_IDLE;
      end
    endcase
    if (conv.abort) begin
      d.st = SAR_IDLE;
      d.busy = 1'b0;
      d.hold = 1'b0;
      d.done = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      q <= '{st: SAR_IDLE, idx: '0, trial: ACP_DATA_RESET, result: ACP_DATA_RESET,
             busy: 1'b0, done: 1'b0, hold: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign conv.busy = q.busy;
  assign conv.done = q.done;
  assign conv.hold = q.hold;
  assign conv.result = q.result;
  assign conv.trial = q.trial;
endmodule

// file: hw/acp_control.sv
// Control-pin logic of an 18-bit successive approximation converter.
// Assumes every pin is asynchronous and goes through the three-stage synchroniser;
// the configuration write strobe comes from logic on the same clock.
//
// Functional notes
// - Output bus enabled only while chip select and read are both low.
// - In slave serial mode chip select also gates the external serial clock.
// - Reset input aborts any conversion in progress.
// - Falling edge of reset forces data outputs to all zeros.
// - Reset clears the serial configuration register.
// - Power-down finishes the running conversion and refuses new ones.
// - Digital interface stays usable during power-down.
// - Falling edge of convert start puts sample-and-hold into hold, starting conversion.
// - Reference shutdown low enables internal reference; high powers it down.
// - Buffer shutdown low enables reference buffer; high powers it down.
// - Bipolar and range-double inputs pick 0-5, 0-10, +-5 or +-10 V.
// - Busy rises at start and falls when result is latched for shifting.
module acp_control
  import acp_pkg::*;
(
  input wire logic clk, // 10 MHz system clock
  input wire logic reset, // Synchronous block reset
  input wire logic resetPin, // Converter reset pin, active high
  input wire logic convertStart_n, // Convert start pin
  input wire logic read_n, // Read strobe pin
  input wire logic chipSelect_n, // Chip select pin
  input wire logic powerdownPin, // Power-down pin
  input wire logic refShutdown, // Internal reference shutdown pin
  input wire logic bufferShutdown, // Reference buffer shutdown pin
  input wire logic bipolarSel, // Bipolar range pin
  input wire logic rangeDoubleSel, // Range doubling pin
  input wire logic outputCodingSel, // High: straight binary, low: two's complement
  input wire logic serialModeSel, // High: slave serial port instead of parallel
  input wire logic serialClkIn, // External serial data clock pin
  input wire logic compareIn, // Comparator answer for current trial
  input wire logic softConfigSel, // High: take range, power-down, coding from register
  input wire logic cfgLoad, // One-cycle configuration write strobe
  input wire logic [ACP_CFG_BITS-1:0] cfgData, // Configuration write data
  output logic busy, // Conversion in progress
  output logic sampleHold, // Sample-and-hold in hold
  output logic [ACP_RES_BITS-1:0] dacTrial, // Trial code for the capacitor array
  output logic [ACP_RES_BITS-1:0] parallelData, // Parallel result bus
  output logic parallelEnable, // Parallel bus drive enable
  output logic serialData, // Serial result bit
  output logic serialEnable, // Serial output drive enable
  output logic refEnable, // Internal reference powered
  output logic bufEnable, // Reference buffer powered
  output logic [1:0] rangeSel, // Selected input range code
  output logic powerDownActive, // Converter core in power-down
  output logic [ACP_CFG_BITS-1:0] configOut // Configuration register contents
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic cnvPrev;
    logic rstPrev;
    logic sclkPrev;
    logic [ACP_CFG_BITS-1:0] cfg;
    logic [ACP_RES_BITS-1:0] shift;
    logic [ACP_RES_BITS-1:0] dataOut;
    logic parEn;
    logic serEn;
    logic serBit;
    logic refEn;
    logic bufEn;
    acp_range_t range;
    logic pdActive;
    logic start;
    logic abort;
  } acp_ctrl_state_t;

  acp_ctrl_state_t q;
  acp_ctrl_state_t d;

  logic [ACP_PIN_COUNT-1:0] pinRaw;
  logic [ACP_PIN_COUNT-1:0] pin;

  acp_conv_if conv ();

  // ****************************************
  // Pin synchronisers
  // ****************************************
  assign pinRaw[ACP_PIN_RESET] = resetPin;
  assign pinRaw[ACP_PIN_CONVERT_N] = convertStart_n;
  assign pinRaw[ACP_PIN_READ_N] = read_n;
  assign pinRaw[ACP_PIN_SELECT_N] = chipSelect_n;
  assign pinRaw[ACP_PIN_POWERDOWN] = powerdownPin;
  assign pinRaw[ACP_PIN_REF_SHDN] = refShutdown;
  assign pinRaw[ACP_PIN_BUF_SHDN] = bufferShutdown;
  assign pinRaw[ACP_PIN_BIPOLAR] = bipolarSel;
  assign pinRaw[ACP_PIN_DOUBLE] = rangeDoubleSel;
  assign pinRaw[ACP_PIN_CODING] = outputCodingSel;
  assign pinRaw[ACP_PIN_SERIAL] = serialModeSel;
  assign pinRaw[ACP_PIN_SCLK] = serialClkIn;
  assign pinRaw[ACP_PIN_COMPARE] = compareIn;

  acp_sync #(
    .W(ACP_PIN_COUNT),
    .INIT(ACP_PIN_INIT)
  ) pinSync (
    .clk(clk),
    .reset(reset),
    .pinIn(pinRaw),
    .level(pin)
  );

  logic softSel;
  logic softCfg;

  acp_sync #(
    .W(1),
    .INIT(1'b0)
  ) softSync (
    .clk(clk),
    .reset(reset),
    .pinIn(softConfigSel),
    .level(softSel)
  );

  // ****************************************
  // Approximation engine
  // ****************************************
  acp_sar engine (
    .clk(clk),
    .reset(reset),
    .conv(conv.engine)
  );

  assign conv.start = q.start;
  assign conv.abort = q.abort;
  // The comparator is already filtered; an extra register would skew every bit decision
  assign conv.compare = pin[ACP_PIN_COMPARE];

  // ****************************************
  // Control logic
  // ****************************************
  logic rstLvl;
  logic cnvFall;
  logic rstFall;
  logic sclkRise;
  logic selected;
  logic reading;
  logic serialMode;
  logic bipolarEff;
  logic doubleEff;
  logic pdEff;
  logic codingEff;
  logic [ACP_RES_BITS-1:0] coded;

  // ****************************************
  // Pin decode
  // ****************************************
  always_comb begin
    softCfg = softSel;
    rstLvl = pin[ACP_PIN_RESET];
    cnvFall = q.cnvPrev & ~pin[ACP_PIN_CONVERT_N];
    rstFall = q.rstPrev & ~rstLvl;
    sclkRise = ~q.sclkPrev & pin[ACP_PIN_SCLK];
    selected = ~pin[ACP_PIN_SELECT_N];
    reading = selected & ~pin[ACP_PIN_READ_N];
    serialMode = pin[ACP_PIN_SERIAL];
    // In software mode the range, power-down and coding pins are don't-cares
    bipolarEff = softCfg ? q.cfg[ACP_CFG_BIPOLAR] : pin[ACP_PIN_BIPOLAR];
    doubleEff = softCfg ? q.cfg[ACP_CFG_DOUBLE] : pin[ACP_PIN_DOUBLE];
    pdEff = softCfg ? q.cfg[ACP_CFG_POWERDOWN] : pin[ACP_PIN_POWERDOWN];
    codingEff = softCfg ? q.cfg[ACP_CFG_CODING] : pin[ACP_PIN_CODING];
    // Two's complement differs from offset binary only in the MSB
    coded = codingEff ? conv.result : (conv.result ^ ACP_MSB_MASK);
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    d = q;
    d.cnvPrev = pin[ACP_PIN_CONVERT_N];
    d.rstPrev = rstLvl;
    d.sclkPrev = pin[ACP_PIN_SCLK];
    d.start = 1'b0;
    d.abort = rstLvl;

    // Starts only on a fresh falling edge; a low level held through reset does not count
    if (cnvFall && !pdEff && !conv.busy && !rstLvl && !q.start) begin
      d.start = 1'b1;
    end

    if (rstLvl) begin
      d.cfg = ACP_CFG_RESET;
    end else if (cfgLoad) begin
      d.cfg = cfgData;
    end

    if (rstFall) begin
      d.dataOut = ACP_DATA_RESET;
      d.shift = ACP_DATA_RESET;
    end else if (conv.done) begin
      d.dataOut = coded;
      d.shift = coded;
    end else if (serialMode && selected && sclkRise) begin
      // Serial clock edges count only while chip select is low
      d.shift = {q.shift[ACP_RES_BITS-2:0], 1'b0};
    end
    d.serBit = d.shift[ACP_RES_BITS-1];

    // Read path ignores power-down so results stay readable
    d.parEn = reading & ~serialMode;
    d.serEn = reading & serialMode;

    d.refEn = ~pin[ACP_PIN_REF_SHDN];
    d.bufEn = ~pin[ACP_PIN_BUF_SHDN];
    d.range = acp_range_t'({bipolarEff, doubleEff});
    d.pdActive = pdEff;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      // Edge trackers start at the idle level of their pins, so no false edge follows reset
      q <= '{
        cnvPrev: 1'b1,
        rstPrev: 1'b0,
        sclkPrev: 1'b0,
        cfg: ACP_CFG_RESET,
        shift: ACP_DATA_RESET,
        dataOut: ACP_DATA_RESET,
        parEn: 1'b0,
        serEn: 1'b0,
        serBit: 1'b0,
        refEn: 1'b0,
        bufEn: 1'b0,
        range: RANGE_0_5,
        pdActive: 1'b0,
        start: 1'b0,
        abort: 1'b0
      };
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign busy = conv.busy;
  assign sampleHold = conv.hold;
  assign dacTrial = conv.trial;
  assign parallelData = q.dataOut;
  assign parallelEnable = q.parEn;
  assign serialData = q.serBit;
  assign serialEnable = q.serEn;
  assign refEnable = q.refEn;
  assign bufEnable = q.bufEn;
  assign rangeSel = q.range;
  assign powerDownActive = q.pdActive;
  assign configOut = q.cfg;

endmodule

// file: testbench/acp_checker.sv
// Assertion checker for the converter control pins, bound to acp_control.
// Assumes three-flop pin synchronisers, so a held pin shows within eight edges.
module acp_checker
  import acp_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic reset, // Block reset
  input wire logic resetPin, // Reset pin
  input wire logic convertStart_n, // Convert start
  input wire logic read_n, // Read strobe
  input wire logic chipSelect_n, // Chip select
  input wire logic refShutdown, // Reference off
  input wire logic bufferShutdown, // Buffer off
  input wire logic bipolarSel, // Bipolar pin
  input wire logic rangeDoubleSel, // Double pin
  input wire logic softConfigSel, // Soft config
  input wire logic busy, // Busy
  input wire logic sampleHold, // Hold
  input wire logic [ACP_RES_BITS-1:0] parallelData, // Data bus
  input wire logic parallelEnable, // Bus drive
  input wire logic serialEnable, // Serial drive
  input wire logic refEnable, // Ref on
  input wire logic bufEnable, // Buffer on
  input wire logic [1:0] rangeSel, // Range
  input wire logic [ACP_CFG_BITS-1:0] configOut // Config
);
  timeunit 1ns;
  timeprecision 1ns;
  // Busy length; an abort by the reset pin may cut it short
  logic [5:0] busyLen_q;
  logic abortSeen_q;
  always_ff @(posedge clk) begin
    busyLen_q <= busy ? busyLen_q + 6'h1 : 6'h0;
    abortSeen_q <= busy && (abortSeen_q || resetPin);
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ****************
  // Properties
  // ****************
  sequence s_pin_reset;
    resetPin[*8];
  endsequence
  sequence s_reset_release;
    s_pin_reset ##1 (!resetPin)[*8];
  endsequence
  property p_bus_enable;
    $rose(parallelEnable) || $rose(serialEnable) |-> !$past(chipSelect_n, 3) && !$past(read_n, 3);
  endproperty
  a_bus_enable: assert property (p_bus_enable) else $error("Bus on without select");
  property p_start;
    $rose(busy) |-> sampleHold && $past(convertStart_n, 10);
  endproperty
  a_start: assert property (p_start) else $error("Bad conversion start");
  property p_busy_len;
    $fell(busy) && !abortSeen_q |-> busyLen_q == 6'h13 && !sampleHold;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("Busy length wrong");
  property p_abort;
    s_pin_reset |-> !busy && !sampleHold && configOut == ACP_CFG_RESET;
  endproperty
  a_abort: assert property (p_abort) else $error("Reset pin ignored");
  property p_zero;
    s_reset_release |-> parallelData == ACP_DATA_RESET;
  endproperty
  a_zero: assert property (p_zero) else $error("Data not cleared");
  property p_ref;
    ($stable(refShutdown))[*8] |-> refEnable != refShutdown;
  endproperty
  a_ref: assert property (p_ref) else $error("Reference state wrong");
  property p_buf;
    ($stable(bufferShutdown))[*8] |-> bufEnable != bufferShutdown;
  endproperty
  a_buf: assert property (p_buf) else $error("Buffer state wrong");
  property p_range;
    (!softConfigSel && $stable(bipolarSel) && $stable(rangeDoubleSel))[*8]
      |-> rangeSel == {bipolarSel, rangeDoubleSel};
  endproperty
  a_range: assert property (p_range) else $error("Range code wrong");
  property p_one_port;
    !(parallelEnable && serialEnable);
  endproperty
  a_one_port: assert property (p_one_port) else $error("Both ports on");
endmodule

// file: testbench/acp_host_model.sv
// Host-side model: comparator answer and reference strap pins.
// Assumes the bench picks the reference setup; outputs follow at once.
module acp_host_model (
  input wire logic keepBits, // Comparator answer
  input wire logic useInternal, // Internal ref wanted
  input wire logic extBuffer, // Buffer on with external ref
  output logic compareIn, // Comparator out
  output logic refShutdown, // Ref off
  output logic bufferShutdown // Buffer off
);
  timeunit 1ns;
  timeprecision 1ns;
  assign compareIn = keepBits;
  assign refShutdown = !useInternal;
  // Buffer may never be off while the internal reference is used
  assign bufferShutdown = useInternal ? 1'h0 : !extBuffer;
endmodule

// file: testbench/testbench.sv
// Self-checking bench for the converter control pins.
// Assumes acp_control, the checker and the host model are compiled first.
module testbench
  import acp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk;
  logic reset = 1'h1, resetPin = 1'h0, convertStart_n = 1'h1, read_n = 1'h1;
  logic chipSelect_n = 1'h1, powerdownPin = 1'h0, bipolarSel = 1'h0, rangeDoubleSel = 1'h0;
  logic outputCodingSel = 1'h1, serialModeSel = 1'h0, serialClkIn = 1'h0, softConfigSel = 1'h0;
  logic cfgLoad = 1'h0, keepBits = 1'h1, useInternal = 1'h1, extBuffer = 1'h0;
  logic [ACP_CFG_BITS-1:0] cfgData = 4'h0;
  logic compareIn, refShutdown, bufferShutdown, busy, sampleHold, parallelEnable;
  logic serialData, serialEnable, refEnable, bufEnable, powerDownActive;
  logic [ACP_CFG_BITS-1:0] configOut;
  logic [ACP_RES_BITS-1:0] dacTrial, parallelData;
  logic [1:0] rangeSel;
  int fails = 0;
  int checked = 0;
  int n;
  acp_control acp_control_i (.clk, .reset, .resetPin, .convertStart_n, .read_n, .chipSelect_n,
    .powerdownPin, .refShutdown, .bufferShutdown, .bipolarSel, .rangeDoubleSel, .outputCodingSel,
    .serialModeSel, .serialClkIn, .compareIn, .softConfigSel, .cfgLoad, .cfgData, .busy,
    .sampleHold, .dacTrial, .parallelData, .parallelEnable, .serialData, .serialEnable,
    .refEnable, .bufEnable, .rangeSel, .powerDownActive, .configOut);
  acp_host_model acp_host_model_i (.keepBits, .useInternal, .extBuffer, .compareIn,
    .refShutdown, .bufferShutdown);
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  // Whole run is under a thousand cycles
  initial begin
    repeat (4000) @(posedge clk);
    fails++;
    complete_run();
  end
  // ****************
  // Helpers
  // ****************
  task automatic check(input logic [ACP_RES_BITS-1:0] seen, input logic [ACP_RES_BITS-1:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic wait_busy(input logic v);
    n = 0;
    while (busy !== v && n < 40) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic start();
    convertStart_n = 1'h0;
    wait_busy(1'h1);
    convertStart_n = 1'h1;
  endtask
  task automatic conv(input logic pd);
    start();
    powerdownPin = pd;
    check(sampleHold, 1'h1);
    check(dacTrial, 18'h2_0000);
    wait_busy(1'h0);
    check(18'(n), 18'h13);
  endtask
  task automatic rd(input logic v);
    read_n = v;
    chipSelect_n = v;
    cyc(8);
  endtask
  // Serial clock slower than eight system clocks
  task automatic pulse();
    serialClkIn = 1'h1;
    cyc(6);
    serialClkIn = 1'h0;
    cyc(6);
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_idle();
    cyc(30);
    check(busy, 1'h0);
  endtask
  task automatic t_convert();
    conv(1'h0);
    check(parallelData, 18'h3_ffff);
    chipSelect_n = 1'h0;
    cyc(8);
    check(parallelEnable, 1'h0);
    rd(1'h0);
    check(parallelEnable, 1'h1);
    rd(1'h1);
    check(parallelEnable, 1'h0);
  endtask
  task automatic t_powerdown();
    conv(1'h1);
    convertStart_n = 1'h0;
    cyc(8);
    convertStart_n = 1'h1;
    cyc(4);
    check(busy, 1'h0);
    check(powerDownActive, 1'h1);
    rd(1'h0);
    check(parallelEnable, 1'h1);
    rd(1'h1);
    powerdownPin = 1'h0;
    cyc(8);
  endtask
  task automatic t_reset_pin();
    cfgData = 4'ha;
    cfgLoad = 1'h1;
    cyc(1);
    cfgLoad = 1'h0;
    check(configOut, 4'ha);
    softConfigSel = 1'h1;
    cyc(8);
    check(rangeSel, 2'h1);
    start();
    resetPin = 1'h1;
    cyc(8);
    check(busy, 1'h0);
    check(configOut, ACP_CFG_RESET);
    check(rangeSel, 2'h0);
    resetPin = 1'h0;
    softConfigSel = 1'h0;
    cyc(8);
    check(parallelData, ACP_DATA_RESET);
  endtask
  // All-zero result in two's complement leaves only the top bit set
  task automatic t_serial();
    keepBits = 1'h0;
    outputCodingSel = 1'h0;
    serialModeSel = 1'h1;
    cyc(8);
    conv(1'h0);
    check(serialData, 1'h1);
    pulse();
    check(serialData, 1'h1);
    rd(1'h0);
    check(serialEnable, 1'h1);
    pulse();
    check(serialData, 1'h0);
    rd(1'h1);
  endtask
  task automatic t_pins();
    for (int i = 0; i < 4; i++) begin
      {bipolarSel, rangeDoubleSel} = i[1:0];
      cyc(8);
      check(rangeSel, i[1:0]);
    end
    for (int i = 0; i < 3; i++) begin
      useInternal = (i == 0);
      extBuffer = (i == 1);
      cyc(8);
      check(refEnable, useInternal);
      check(bufEnable, useInternal || extBuffer);
    end
  endtask
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge clk);
    reset = 1'h0;
    t_idle();
    t_convert();
    t_powerdown();
    t_reset_pin();
    t_serial();
    t_pins();
    complete_run();
  end
endmodule
bind acp_control acp_checker acp_checker_i (.clk, .reset, .resetPin, .convertStart_n, .read_n,
  .chipSelect_n, .refShutdown, .bufferShutdown, .bipolarSel, .rangeDoubleSel, .softConfigSel,
  .busy, .sampleHold, .parallelData, .parallelEnable, .serialEnable, .refEnable, .bufEnable,
  .rangeSel, .configOut);
